// file: hdl/rx_oob_status_detect.sv
// receive out-of-band status: quiet-line flag, sata com decode, status code and symbol valid
// assumes all inputs are synchronous to i_clk_sys, which is also the squelch reference clock
`timescale 1ns/1ns
module rx_oob_status_detect (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [7:0] i_line_diff_mv,
  input wire logic [2:0] i_quiet_threshold_select,
  input wire logic [3:0] i_squelch_clock_divider,
  input wire logic i_status_format_select,
  input wire logic [3:0] i_com_burst_count,
  input wire logic [3:0] i_com_gap_count,
  input wire logic [5:0] i_burst_min_cycles,
  input wire logic [5:0] i_burst_max_cycles,
  input wire logic [5:0] i_init_gap_min_cycles,
  input wire logic [5:0] i_init_gap_max_cycles,
  input wire logic [5:0] i_wake_gap_min_cycles,
  input wire logic [5:0] i_wake_gap_max_cycles,
  input wire logic i_rx_detect_active,
  input wire logic i_rx_detect_present,
  input wire logic i_decode_err,
  input wire logic i_disparity_err,
  input wire logic i_ebuf_overflow,
  input wire logic i_ebuf_underflow,
  input wire logic i_status_clear,
  input wire logic i_tx_oob_sequence_request,
  input wire logic i_tx_oob_sequence_done,
  input wire logic i_symbol_lock,
  input wire logic i_word_valid,
  input wire logic [15:0] i_rx_word,
  input wire logic [1:0] i_rx_control_flags,
  output logic o_rx_line_quiet,
  output logic [2:0] o_rx_status_code,
  output logic o_rx_symbol_valid,
  output logic [15:0] o_rx_word,
  output logic [1:0] o_rx_control_flags
);

  logic tick;
  logic init_match;
  logic wake_match;

  logic quiet_r, quiet_nxt;
  logic ovf_r, ovf_nxt;
  logic unf_r, unf_nxt;
  logic pend_r, pend_nxt;
  logic tx_done;
  logic [2:0] status_r, status_nxt;
  logic valid_r, valid_nxt;
  logic [15:0] word_r, word_nxt;
  logic [1:0] flags_r, flags_nxt;
  rx_oob_pkg::status_format_t fmt;

  assign fmt = rx_oob_pkg::status_format_t'(i_status_format_select);

  squelch_tick_gen squelch_tick_gen_inst (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_squelch_clock_divider(i_squelch_clock_divider),
    .o_tick(tick)
  );

  // bursts are line activity, gaps are quiet stretches; same level o_rx_line_quiet shows
  com_burst_detector com_burst_detector_inst (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_tick(tick),
    .i_quiet(quiet_r),
    .i_com_burst_count(i_com_burst_count),
    .i_com_gap_count(i_com_gap_count),
    .i_burst_min_cycles(i_burst_min_cycles),
    .i_burst_max_cycles(i_burst_max_cycles),
    .i_init_gap_min_cycles(i_init_gap_min_cycles),
    .i_init_gap_max_cycles(i_init_gap_max_cycles),
    .i_wake_gap_min_cycles(i_wake_gap_min_cycles),
    .i_wake_gap_max_cycles(i_wake_gap_max_cycles),
    .o_init_match(init_match),
    .o_wake_match(wake_match)
  );

  // quiet-line detect; registered so the output is glitch free, costs one cycle
  always_comb begin
    quiet_nxt = i_line_diff_mv < rx_oob_pkg::thr_mv(i_quiet_threshold_select);
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      quiet_r <= 1'b1;
    end else begin
      quiet_r <= quiet_nxt;
    end
  end

  // sticky buffer errors and transmit oob tracking; a set wins over a clear
  always_comb begin
    ovf_nxt = (ovf_r && !i_status_clear) || i_ebuf_overflow;
    unf_nxt = (unf_r && !i_status_clear) || i_ebuf_underflow;
    tx_done = pend_r && i_tx_oob_sequence_done;
    pend_nxt = i_tx_oob_sequence_request || (pend_r && !i_tx_oob_sequence_done);
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      ovf_r <= ovf_nxt;
      unf_r <= unf_nxt;
      pend_r <= pend_nxt;
    end
  end

  // status code; in pci express format sticky buffer errors outrank per-cycle errors so those never mask them
  always_comb begin
    status_nxt = rx_oob_pkg::ST_OK;
    case (fmt)
      rx_oob_pkg::FMT_PCIE: begin
        if (ovf_nxt) begin
          status_nxt = rx_oob_pkg::ST_OVERFLOW;
        end else if (unf_nxt) begin
          status_nxt = rx_oob_pkg::ST_UNDERFLOW;
        end else if (i_decode_err) begin
          status_nxt = rx_oob_pkg::ST_DECODE_ERR;
        end else if (i_disparity_err) begin
          status_nxt = rx_oob_pkg::ST_DISPARITY;
        end else if (i_rx_detect_active && i_rx_detect_present) begin
          status_nxt = rx_oob_pkg::ST_PRESENT;
        end
      end
      rx_oob_pkg::FMT_SATA: begin
        status_nxt[rx_oob_pkg::SATA_BIT_TX_DONE] = tx_done;
        status_nxt[rx_oob_pkg::SATA_BIT_WAKE] = wake_match;
        status_nxt[rx_oob_pkg::SATA_BIT_INIT] = init_match;
      end
      default: begin
        status_nxt = rx_oob_pkg::ST_OK;
      end
    endcase
  end

  // word, flags and valid move together so valid never leads its data
  always_comb begin
    valid_nxt = i_symbol_lock && i_word_valid;
    word_nxt = i_rx_word;
    flags_nxt = i_rx_control_flags;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_r <= rx_oob_pkg::STATUS_RESET;
      valid_r <= 1'b0;
      word_r <= 16'h0000;
      flags_r <= 2'h0;
    end else begin
      status_r <= status_nxt;
      valid_r <= valid_nxt;
      word_r <= word_nxt;
      flags_r <= flags_nxt;
    end
  end

  assign o_rx_line_quiet = quiet_r;
  assign o_rx_status_code = status_r;
  assign o_rx_symbol_valid = valid_r;
  assign o_rx_word = word_r;
  assign o_rx_control_flags = flags_r;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  a_quiet_level: assert property (
    (i_line_diff_mv < rx_oob_pkg::thr_mv(i_quiet_threshold_select)) |=> o_rx_line_quiet)
    else $error("quiet flag low while level below threshold");

  a_active_level: assert property (
    (i_line_diff_mv >= rx_oob_pkg::thr_mv(i_quiet_threshold_select)) |=> !o_rx_line_quiet)
    else $error("quiet flag high while level above threshold");

  a_no_reserved: assert property (
    (fmt == rx_oob_pkg::FMT_PCIE) |=> (o_rx_status_code != 3'h1 && o_rx_status_code != 3'h2))
    else $error("reserved pci express status produced");

  a_present_code: assert property (
    (fmt == rx_oob_pkg::FMT_PCIE && i_rx_detect_active && i_rx_detect_present && !ovf_nxt && !unf_nxt
      && !i_decode_err && !i_disparity_err) |=> o_rx_status_code == rx_oob_pkg::ST_PRESENT)
    else $error("receiver present not reported");

  a_decode_code: assert property (
    (fmt == rx_oob_pkg::FMT_PCIE && i_decode_err && !ovf_nxt && !unf_nxt) |=> o_rx_status_code == 3'h4)
    else $error("decode error not reported");

  a_disparity_code: assert property (
    (fmt == rx_oob_pkg::FMT_PCIE && i_disparity_err && !i_decode_err && !ovf_nxt && !unf_nxt)
      |=> o_rx_status_code == 3'h7)
    else $error("disparity error not reported");

  a_overflow_hold: assert property (
    (fmt == rx_oob_pkg::FMT_PCIE && i_ebuf_overflow) ##1 (!i_status_clear && fmt == rx_oob_pkg::FMT_PCIE)
      |=> o_rx_status_code == 3'h5 ##0 $past(o_rx_status_code) == 3'h5)
    else $error("overflow status not held until cleared");

  a_underflow_hold: assert property (
    (unf_r && !i_status_clear) |=> unf_r)
    else $error("underflow sticky flag lost without clear");

  a_sata_bits: assert property (
    (fmt == rx_oob_pkg::FMT_SATA) |=> (o_rx_status_code[2] == $past(init_match)
      && o_rx_status_code[1] == $past(wake_match)))
    else $error("sata com status bit does not follow detector");

  a_tx_done: assert property (
    (fmt == rx_oob_pkg::FMT_SATA && pend_r && i_tx_oob_sequence_done) |=> o_rx_status_code[0])
    else $error("transmit oob completion not flagged");

  a_symbol_valid: assert property (
    o_rx_symbol_valid |-> $past(i_symbol_lock) && $past(i_word_valid) && o_rx_word == $past(i_rx_word))
    else $error("symbol valid without lock or with stale word");

  a_valid_low: assert property (
    !(i_symbol_lock && i_word_valid) |=> !o_rx_symbol_valid)
    else $error("symbol valid high without lock and valid word");

  a_flags_follow: assert property (
    o_rx_symbol_valid |-> o_rx_control_flags == $past(i_rx_control_flags))
    else $error("control flags do not match their symbol");

  a_word_track: assert property (
    i_word_valid |=> o_rx_word == $past(i_rx_word))
    else $error("received word not passed on");

  // sticky flags; a set beats a clear that lands in the same cycle
  a_overflow_set: assert property (
    i_ebuf_overflow |=> ovf_r)
    else $error("overflow event did not set the sticky flag");

  a_underflow_set: assert property (
    i_ebuf_underflow |=> unf_r)
    else $error("underflow event did not set the sticky flag");

  a_overflow_clear: assert property (
    (ovf_r && i_status_clear && !i_ebuf_overflow) |=> !ovf_r)
    else $error("overflow sticky flag survived a clear");

  a_underflow_clear: assert property (
    (unf_r && i_status_clear && !i_ebuf_underflow) |=> !unf_r)
    else $error("underflow sticky flag survived a clear");

  a_overflow_code: assert property (
    (fmt == rx_oob_pkg::FMT_PCIE && ovf_r && !i_status_clear)
      |=> o_rx_status_code == rx_oob_pkg::ST_OVERFLOW)
    else $error("sticky overflow not shown as status");

  a_underflow_code: assert property (
    (fmt == rx_oob_pkg::FMT_PCIE && unf_r && !ovf_r && !i_status_clear && !i_ebuf_overflow)
      |=> o_rx_status_code == rx_oob_pkg::ST_UNDERFLOW)
    else $error("sticky underflow not shown as status");

  a_ok_code: assert property (
    (fmt == rx_oob_pkg::FMT_PCIE && !ovf_nxt && !unf_nxt && !i_decode_err && !i_disparity_err
      && !(i_rx_detect_active && i_rx_detect_present)) |=> o_rx_status_code == rx_oob_pkg::ST_OK)
    else $error("status not 000 with nothing to report");

  // sata bit 0 needs a request first; a done on its own is ignored
  a_pend_arm: assert property (
    i_tx_oob_sequence_request |=> pend_r)
    else $error("transmit oob request not remembered");

  a_tx_ignored: assert property (
    (fmt == rx_oob_pkg::FMT_SATA && !pend_r) |=> !o_rx_status_code[0])
    else $error("transmit oob completion flagged without a request");

  a_tx_cause: assert property (
    ($past(fmt) == rx_oob_pkg::FMT_SATA && o_rx_status_code[0])
      |-> $past(pend_r) && $past(i_tx_oob_sequence_done))
    else $error("transmit oob completion flag without its cause");

  a_com_excl: assert property (
    !(init_match && wake_match))
    else $error("comwake and comreset indications at once");

endmodule // rx_oob_status_detect

// file: common/rx_oob_pkg.sv
// constants, encodings and helpers shared by the receive out-of-band status block
// assumes a single 250 MHz system clock that also serves as the squelch reference clock
package rx_oob_pkg;

  typedef enum logic {FMT_PCIE, FMT_SATA} status_format_t;

  typedef enum logic {GAP_INIT, GAP_WAKE} gap_type_t;

  // pci express status codes
  localparam logic [2:0] ST_OK = 3'h0;
  localparam logic [2:0] ST_PRESENT = 3'h3;
  localparam logic [2:0] ST_DECODE_ERR = 3'h4;
  localparam logic [2:0] ST_OVERFLOW = 3'h5;
  localparam logic [2:0] ST_UNDERFLOW = 3'h6;
  localparam logic [2:0] ST_DISPARITY = 3'h7;
  localparam logic [2:0] STATUS_RESET = 3'h0;

  // sata status bit positions
  localparam int SATA_BIT_TX_DONE = 0;
  localparam int SATA_BIT_WAKE = 1;
  localparam int SATA_BIT_INIT = 2;

  // detector defaults, in squelch clock cycles or counts
  localparam logic [3:0] COM_BURST_COUNT_DEF = 4'h4;
  localparam logic [3:0] COM_GAP_COUNT_DEF = 4'h3;
  localparam logic [5:0] BURST_MIN_DEF = 6'h05;
  localparam logic [5:0] BURST_MAX_DEF = 6'h07;
  localparam logic [5:0] INIT_GAP_MIN_DEF = 6'h0C;
  localparam logic [5:0] INIT_GAP_MAX_DEF = 6'h16;
  localparam logic [5:0] WAKE_GAP_MIN_DEF = 6'h02;
  localparam logic [5:0] WAKE_GAP_MAX_DEF = 6'h07;
  localparam logic [5:0] LEN_SAT = 6'h3F;
  localparam logic [3:0] COUNT_SAT = 4'hF;

  // squelch clock
  localparam int REF_CLK_MHZ = 250;
  localparam int SQUELCH_TARGET_MHZ = 25;
  localparam logic [3:0] DIV_SUGGESTED = 4'(REF_CLK_MHZ / SQUELCH_TARGET_MHZ);
  localparam logic [3:0] DIV_RESET = 4'h1;

  // nominal quiet threshold in mV for each select code
  function automatic logic [7:0] thr_mv(input logic [2:0] code);
    case (code)
      3'h0: thr_mv = 8'h46;
      3'h1: thr_mv = 8'h55;
      3'h2: thr_mv = 8'h5C;
      3'h3: thr_mv = 8'h63;
      3'h4: thr_mv = 8'h69;
      3'h5: thr_mv = 8'h70;
      3'h6: thr_mv = 8'h76;
      default: thr_mv = 8'h7F;
    endcase
  endfunction

  function automatic logic div_valid(input logic [3:0] d);
    div_valid = (d == 4'h1) || ((d[0] == 1'b0) && (d >= 4'h2) && (d <= 4'hE));
  endfunction

  function automatic logic in_window(input logic [5:0] v, input logic [5:0] lo, input logic [5:0] hi);
    in_window = (v >= lo) && (v <= hi);
  endfunction

endpackage

// file: hdl/squelch_tick_gen.sv
// squelch clock as a one-cycle tick, reference clock divided by a legal divider
// assumes the reference clock is the system clock; illegal divider settings fall back to 1
`timescale 1ns/1ns
module squelch_tick_gen (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [3:0] i_squelch_clock_divider,
  output logic o_tick
);

  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    div_nxt = rx_oob_pkg::div_valid(i_squelch_clock_divider) ? i_squelch_clock_divider : rx_oob_pkg::DIV_RESET;
    if (cnt_r + 4'h1 >= div_r) begin
      cnt_nxt = 4'h0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 4'h1;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_r <= rx_oob_pkg::DIV_RESET;
      cnt_r <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tick = tick_r;

  a_tick_spacing: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (tick_r && div_r >= 4'h2 && $stable(div_r)) |=> !tick_r)
    else $error("squelch tick came faster than the divider allows");

endmodule // squelch_tick_gen

// file: hdl/com_burst_detector.sv
// counts out-of-band bursts and gaps on squelch ticks, flags comreset/cominit and comwake
// assumes i_quiet is a registered quiet-line level in the same clock domain
`timescale 1ns/1ns
module com_burst_detector (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_tick,
  input wire logic i_quiet,
  input wire logic [3:0] i_com_burst_count,
  input wire logic [3:0] i_com_gap_count,
  input wire logic [5:0] i_burst_min_cycles,
  input wire logic [5:0] i_burst_max_cycles,
  input wire logic [5:0] i_init_gap_min_cycles,
  input wire logic [5:0] i_init_gap_max_cycles,
  input wire logic [5:0] i_wake_gap_min_cycles,
  input wire logic [5:0] i_wake_gap_max_cycles,
  output logic o_init_match,
  output logic o_wake_match
);

  typedef enum logic [1:0] {S_WAIT, S_BURST, S_GAP} com_state_t;

  com_state_t state_r, state_nxt;
  logic [5:0] len_r, len_nxt;
  logic [3:0] bursts_r, bursts_nxt;
  logic [3:0] gaps_r, gaps_nxt;
  rx_oob_pkg::gap_type_t gtype_r, gtype_nxt;
  logic init_r, init_nxt;
  logic wake_r, wake_nxt;
  logic burst_ok;
  logic init_ok;
  logic wake_ok;

  assign burst_ok = rx_oob_pkg::in_window(len_r, i_burst_min_cycles, i_burst_max_cycles);
  assign init_ok = rx_oob_pkg::in_window(len_r, i_init_gap_min_cycles, i_init_gap_max_cycles);
  assign wake_ok = rx_oob_pkg::in_window(len_r, i_wake_gap_min_cycles, i_wake_gap_max_cycles);

  always_comb begin
    state_nxt = state_r;
    len_nxt = len_r;
    bursts_nxt = bursts_r;
    gaps_nxt = gaps_r;
    gtype_nxt = gtype_r;
    init_nxt = 1'b0;
    wake_nxt = 1'b0;
    if (i_tick) begin
      len_nxt = (len_r == rx_oob_pkg::LEN_SAT) ? len_r : len_r + 6'h01;
      case (state_r)
        S_WAIT: begin
          if (!i_quiet) begin
            state_nxt = S_BURST;
            len_nxt = 6'h01;
          end
        end
        S_BURST: begin
          if (i_quiet) begin
            len_nxt = 6'h01;
            if (!burst_ok) begin
              state_nxt = S_WAIT;
              bursts_nxt = 4'h0;
              gaps_nxt = 4'h0;
            end else if ({1'b0, bursts_r} + 5'h01 >= {1'b0, i_com_burst_count} && gaps_r >= i_com_gap_count) begin
              init_nxt = (gtype_r == rx_oob_pkg::GAP_INIT);
              wake_nxt = (gtype_r == rx_oob_pkg::GAP_WAKE);
              state_nxt = S_WAIT;
              bursts_nxt = 4'h0;
              gaps_nxt = 4'h0;
            end else begin
              state_nxt = S_GAP;
              bursts_nxt = (bursts_r == rx_oob_pkg::COUNT_SAT) ? bursts_r : bursts_r + 4'h1;
            end
          end
        end
        S_GAP: begin
          if (!i_quiet) begin
            state_nxt = S_BURST;
            len_nxt = 6'h01;
            if (init_ok) begin
              gtype_nxt = rx_oob_pkg::GAP_INIT;
              gaps_nxt = (gtype_r != rx_oob_pkg::GAP_INIT) ? 4'h1 : gaps_r + 4'h1;
            end else if (wake_ok) begin
              gtype_nxt = rx_oob_pkg::GAP_WAKE;
              gaps_nxt = (gtype_r != rx_oob_pkg::GAP_WAKE) ? 4'h1 : gaps_r + 4'h1;
            end else begin
              bursts_nxt = 4'h0;
              gaps_nxt = 4'h0;
            end
            if (gaps_nxt == rx_oob_pkg::COUNT_SAT) begin
              gaps_nxt = gaps_r;
            end
          end
        end
        default: begin
          state_nxt = S_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= S_WAIT;
      len_r <= 6'h00;
      bursts_r <= 4'h0;
      gaps_r <= 4'h0;
      gtype_r <= rx_oob_pkg::GAP_INIT;
      init_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      len_r <= len_nxt;
      bursts_r <= bursts_nxt;
      gaps_r <= gaps_nxt;
      gtype_r <= gtype_nxt;
      init_r <= init_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign o_init_match = init_r;
  assign o_wake_match = wake_r;

  a_burst_reject: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (i_tick && state_r == S_BURST && i_quiet && (len_r < i_burst_min_cycles || len_r > i_burst_max_cycles))
      |=> (bursts_r == 4'h0 && state_r == S_WAIT && !init_r && !wake_r))
    else $error("out-of-window burst was not rejected");

  a_gap_restart: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (i_tick && state_r == S_GAP && !i_quiet && init_ok && gtype_r == rx_oob_pkg::GAP_WAKE) |=> gaps_r == 4'h1)
    else $error("gap count not restarted on gap type change");

  a_match_count: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (init_r || wake_r) |-> ($past(bursts_r) + 4'h1 >= $past(i_com_burst_count) && $past(gaps_r) >= $past(i_com_gap_count)))
    else $error("com match declared with too few bursts or gaps");

endmodule // com_burst_detector

// file: test/oob_line_model.sv
// remote serial transmitter: differential amplitude with out-of-band bursts and gaps
// assumes bench calls send from its main process; force lets the bench set a level directly
`timescale 1ns/1ns
module oob_line_model (
  input wire logic i_clk_sys,
  input wire logic i_force_en,
  input wire logic [7:0] i_force_mv,
  output logic [7:0] o_diff_mv
);
  logic burst_on = 1'b0;
  logic [4:0] wiggle = 5'h00;
  initial o_diff_mv = 8'h00;
  // unless forced, amplitude never stands still, so a stuck sample cannot pass by luck
  always @(posedge i_clk_sys) begin
    wiggle <= wiggle + 5'h07;
    if (i_force_en)
      o_diff_mv <= i_force_mv;
    else if (burst_on)
      o_diff_mv <= 8'hC8 - {3'h0, wiggle};
    else
      o_diff_mv <= {3'h0, wiggle};
  end
  // lengths in squelch ticks, div clocks per tick; last gap may be of another kind
  task automatic send(input int nb, input int blen, input int gap, input int last, input int div);
    for (int b = 0; b < nb; b++) begin
      @(posedge i_clk_sys);
      burst_on <= 1'b1;
      repeat (blen * div) @(posedge i_clk_sys);
      burst_on <= 1'b0;
      if (b < nb - 1)
        repeat (((b == nb - 2) ? last : gap) * div - 1) @(posedge i_clk_sys);
    end
  endtask
endmodule // oob_line_model

// file: test/rx_oob_status_detect_bench.sv
// self-checking bench for rx_oob_status_detect with oob_line_model on the line
// assumes one 250 MHz clock; status results are noted in a queue and matched by a monitor
`timescale 1ns/1ns
module rx_oob_status_detect_bench;
  logic i_clk_sys = 1'b0, i_arst_n = 1'b0;
  logic [7:0] i_line_diff_mv;
  logic [2:0] i_quiet_threshold_select = 3'h0;
  logic [3:0] i_squelch_clock_divider = rx_oob_pkg::DIV_SUGGESTED;
  logic i_status_format_select = 1'b0;
  logic [3:0] i_com_burst_count = rx_oob_pkg::COM_BURST_COUNT_DEF;
  logic [3:0] i_com_gap_count = rx_oob_pkg::COM_GAP_COUNT_DEF;
  logic [5:0] i_burst_min_cycles = rx_oob_pkg::BURST_MIN_DEF, i_burst_max_cycles = rx_oob_pkg::BURST_MAX_DEF;
  logic [5:0] i_init_gap_min_cycles = rx_oob_pkg::INIT_GAP_MIN_DEF;
  logic [5:0] i_init_gap_max_cycles = rx_oob_pkg::INIT_GAP_MAX_DEF;
  logic [5:0] i_wake_gap_min_cycles = rx_oob_pkg::WAKE_GAP_MIN_DEF;
  logic [5:0] i_wake_gap_max_cycles = rx_oob_pkg::WAKE_GAP_MAX_DEF;
  logic i_rx_detect_active = 1'b0, i_rx_detect_present = 1'b0, i_decode_err = 1'b0, i_disparity_err = 1'b0;
  logic i_ebuf_overflow = 1'b0, i_ebuf_underflow = 1'b0, i_status_clear = 1'b0;
  logic i_tx_oob_sequence_request = 1'b0, i_tx_oob_sequence_done = 1'b0;
  logic i_symbol_lock = 1'b0, i_word_valid = 1'b0;
  logic [15:0] i_rx_word = 16'h0000;
  logic [1:0] i_rx_control_flags = 2'h0;
  logic o_rx_line_quiet, o_rx_symbol_valid;
  logic [2:0] o_rx_status_code;
  logic [15:0] o_rx_word;
  logic [1:0] o_rx_control_flags;
  logic force_en = 1'b0;
  logic [7:0] force_mv = 8'h00;
  int errors = 0, n_checks = 0;
  logic [2:0] notes[$];
  logic [2:0] prev_code = 3'h0;
  logic [1:0] quiet_sync = 2'h3;
  logic [15:0] rnd = 16'h2B94;
  logic [7:0] thr[8] = '{8'h46, 8'h55, 8'h5C, 8'h63, 8'h69, 8'h70, 8'h76, 8'h7F};

  always #2 i_clk_sys = ~i_clk_sys;

  // fabric side: quiet flag crosses into its domain through two flops
  always @(posedge i_clk_sys) quiet_sync <= {quiet_sync[0], o_rx_line_quiet};

  rx_oob_status_detect rx_oob_status_detect_inst (.i_clk_sys, .i_arst_n, .i_line_diff_mv,
    .i_quiet_threshold_select, .i_squelch_clock_divider, .i_status_format_select, .i_com_burst_count,
    .i_com_gap_count, .i_burst_min_cycles, .i_burst_max_cycles, .i_init_gap_min_cycles, .i_init_gap_max_cycles,
    .i_wake_gap_min_cycles, .i_wake_gap_max_cycles, .i_rx_detect_active, .i_rx_detect_present, .i_decode_err,
    .i_disparity_err, .i_ebuf_overflow, .i_ebuf_underflow, .i_status_clear, .i_tx_oob_sequence_request,
    .i_tx_oob_sequence_done, .i_symbol_lock, .i_word_valid, .i_rx_word, .i_rx_control_flags, .o_rx_line_quiet,
    .o_rx_status_code, .o_rx_symbol_valid, .o_rx_word, .o_rx_control_flags);

  oob_line_model oob_line_model_inst (.i_clk_sys(i_clk_sys), .i_force_en(force_en), .i_force_mv(force_mv),
    .o_diff_mv(i_line_diff_mv));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // mask bits: decode, disparity, overflow, underflow, clear, detect
  task automatic ev(input logic [5:0] m, input logic [2:0] note, input logic [2:0] hold);
    @(posedge i_clk_sys);
    {i_decode_err, i_disparity_err, i_ebuf_overflow, i_ebuf_underflow, i_status_clear, i_rx_detect_active} <= m;
    i_rx_detect_present <= m[0];
    if (note !== 3'h0)
      notes.push_back(note);
    @(posedge i_clk_sys);
    {i_decode_err, i_disparity_err, i_ebuf_overflow, i_ebuf_underflow, i_status_clear, i_rx_detect_active} <= 6'h00;
    i_rx_detect_present <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    check("status after event", {13'h0, o_rx_status_code}, {13'h0, hold});
  endtask

  task automatic tx_pulse(input logic req, input logic [2:0] note);
    @(posedge i_clk_sys);
    if (req)
      i_tx_oob_sequence_request <= 1'b1;
    else
      i_tx_oob_sequence_done <= 1'b1;
    if (note !== 3'h0)
      notes.push_back(note);
    @(posedge i_clk_sys);
    i_tx_oob_sequence_request <= 1'b0;
    i_tx_oob_sequence_done <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
  endtask

  // long quiet after each sequence: that gap fits neither window, so counts start afresh
  task automatic seq(input int nb, input int blen, input int gap, input int last, input logic [2:0] note);
    if (note !== 3'h0)
      notes.push_back(note);
    oob_line_model_inst.send(nb, blen, gap, last, int'(i_squelch_clock_divider));
    repeat (400) @(posedge i_clk_sys);
    check("notes left", 16'(notes.size()), 16'h0000);
  endtask

  // a result is a change of the status code to a nonzero value
  always begin
    @(posedge i_clk_sys);
    #1;
    if (o_rx_status_code !== prev_code && o_rx_status_code !== 3'h0) begin
      if (notes.size() == 0)
        check("unexpected status", {13'h0, o_rx_status_code}, 16'h0000);
      else
        check("status", {13'h0, o_rx_status_code}, {13'h0, notes.pop_front()});
    end
    prev_code = o_rx_status_code;
  end

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    errors++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    repeat (5) @(posedge i_clk_sys);
    #1;
    check("valid in reset", {15'h0, o_rx_symbol_valid}, 16'h0000);
    @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    force_en <= 1'b1;
    for (int s = 0; s < 16; s++) begin
      @(posedge i_clk_sys);
      rnd = lfsr(rnd);
      i_quiet_threshold_select <= 3'(s / 2);
      force_mv <= s[0] ? thr[s / 2] + 8'h01 + {5'h00, rnd[2:0]} : thr[s / 2] - 8'h01 - {5'h00, rnd[2:0]};
      repeat (2) @(posedge i_clk_sys);
      #1;
      check("line quiet", {15'h0, o_rx_line_quiet}, {15'h0, ~s[0]});
      if (s > 0)
        check("synced quiet", {15'h0, quiet_sync[1]}, {15'h0, s[0]});
    end
    force_en <= 1'b0;
    i_quiet_threshold_select <= 3'h0;
    $display("test quiet threshold done");
    for (int i = 0; i < 30; i++) begin
      @(posedge i_clk_sys);
      rnd = lfsr(rnd);
      i_symbol_lock <= rnd[0];
      i_word_valid <= rnd[1];
      i_rx_word <= rnd;
      i_rx_control_flags <= rnd[3:2];
      @(posedge i_clk_sys);
      #1;
      check("symbol valid", {15'h0, o_rx_symbol_valid}, {15'h0, rnd[0] & rnd[1]});
      if (rnd[0] & rnd[1]) begin
        check("word", o_rx_word, rnd);
        check("flags", {14'h0, o_rx_control_flags}, {14'h0, rnd[3:2]});
      end
    end
    $display("test symbol valid done");
    ev(6'h20, 3'h4, 3'h0);
    ev(6'h10, 3'h7, 3'h0);
    ev(6'h01, 3'h3, 3'h0);
    ev(6'h08, 3'h5, 3'h5);
    ev(6'h20, 3'h0, 3'h5);
    ev(6'h02, 3'h0, 3'h0);
    ev(6'h24, 3'h6, 3'h6);
    ev(6'h02, 3'h0, 3'h0);
    ev(6'h0A, 3'h5, 3'h5);
    ev(6'h02, 3'h0, 3'h0);
    $display("test pcie status done");
    @(posedge i_clk_sys);
    i_status_format_select <= 1'b1;
    tx_pulse(1'b0, 3'h0);
    tx_pulse(1'b1, 3'h0);
    tx_pulse(1'b0, 3'h1);
    tx_pulse(1'b0, 3'h0);
    seq(4, 6, 17, 17, 3'h4);
    seq(4, 6, 5, 5, 3'h2);
    seq(4, 10, 17, 17, 3'h0);
    seq(4, 6, 25, 25, 3'h0);
    seq(4, 6, 17, 5, 3'h0);
    seq(3, 6, 17, 17, 3'h0);
    i_com_burst_count <= 4'h3;
    i_com_gap_count <= 4'h2;
    seq(3, 6, 17, 17, 3'h4);
    $display("test sata status done");
    conclude();
  end
endmodule // rx_oob_status_detect_bench
